// *** core/cssc_pkg.sv ***
package cssc_pkg;

  // ==========================================================================
  // Fuse encodings (one = unprogrammed, zero = programmed)
  // ==========================================================================
  localparam logic [3:0] CSSC_SEL_FACTORY = 4'h1;
  localparam logic [1:0] CSSC_SUT_FACTORY = 2'h2;
  localparam logic [3:0] CSSC_SEL_XTAL_LO = 4'hA;
  localparam logic [3:0] CSSC_SEL_LFXTAL = 4'h9;
  localparam logic [3:0] CSSC_SEL_RC_LO = 4'h5;
  localparam logic [3:0] CSSC_SEL_INTRC_LO = 4'h1;
  localparam logic [3:0] CSSC_SEL_EXTCLK = 4'h0;

  // ==========================================================================
  // Start-up counts in cycles of the selected source
  // ==========================================================================
  localparam logic [15:0] CSSC_CK_6 = 16'h0006;
  localparam logic [15:0] CSSC_CK_18 = 16'h0012;
  localparam logic [15:0] CSSC_CK_258 = 16'h0102;
  localparam logic [15:0] CSSC_CK_1K = 16'h0400;
  localparam logic [15:0] CSSC_CK_16K = 16'h4000;
  localparam logic [15:0] CSSC_CK_32K = 16'h8000;

  // ==========================================================================
  // Reset delay in watchdog oscillator cycles
  // ==========================================================================
  localparam int CSSC_WD_SHORT = 4096;
  localparam int CSSC_WD_LONG = 65536;

  typedef enum logic [1:0] {
    CSSC_SRC_XTAL = 2'b00,
    CSSC_SRC_LFXTAL = 2'b01,
    CSSC_SRC_RC = 2'b10,
    CSSC_SRC_CLK = 2'b11
  } cssc_src_e;

  typedef enum logic [1:0] {
    CSSC_DLY_NONE = 2'b00,
    CSSC_DLY_SHORT = 2'b01,
    CSSC_DLY_LONG = 2'b10
  } cssc_dly_e;

  typedef struct packed {
    cssc_src_e src;
    logic internal_rc;
    logic [1:0] freq_range;
    logic [15:0] wake_count;
    cssc_dly_e reset_delay;
  } cssc_cfg_s;

  typedef struct packed {
    logic core_en;
    logic peripheral_en;
    logic nvm_en;
    logic converter_en;
    logic async_timer_en;
  } cssc_gates_s;

endpackage : cssc_pkg

// *** core/cssc_top.sv ***
`timescale 1ns/100ps
// Contract
// (RL1) Four-bit source select: crystal, low-freq crystal, external RC, internal RC, external clock.
// (RL2) Fuse bit one means unprogrammed, zero means programmed.
// (RL3) Wake from power-down/save counts selected-source cycles before execution starts.
// (RL4) Reset start adds 4096 or 65536 watchdog oscillator cycles.
// (RL5) Factory fuses: source select 0001, start-up time 10.
// (RL6) Core clock gated off halts all core operation.
// (RL7) Peripheral clock gated; some external interrupts still detected asynchronously.
// (RL8) Two-wire address recognition proceeds asynchronously while peripheral clock halted.
// (RL9) NVM interface clock gated together with core clock.
// (RL10) Async timer allowed only on internal oscillator, main clock above four times; the code checks only the internal oscillator.
// (RL11) Converter domain keeps running while core and peripheral clocks halted.
// (RL12) Crystal upper select bits 101/110/111 choose range; option fuse widens it.
// (RL13) Crystal select bit zero with start-up fuses picks wake count and reset delay.
// (RL14) Low-freq crystal start-up fuses 00/01/10 pick 1K/1K/32K and delays.
// (RL15) Fetch held until source count then watchdog delay complete, in sequence.
module cssc_top #(
  parameter int WD_SHORT_CYCLES = cssc_pkg::CSSC_WD_SHORT,
  parameter int WD_LONG_CYCLES = cssc_pkg::CSSC_WD_LONG
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SRC_CLK_TICK,
  input wire logic WD_OSC_TICK,
  input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic OSCILLATOR_OPTION_FUSE,
  input wire logic USE_FACTORY_FUSES,
  input wire logic WAKE_REQ,
  input wire logic SLEEP_CORE,
  input wire logic SLEEP_PERIPHERAL,
  input wire logic ASYNC_TIMER_REQ,
  output cssc_pkg::cssc_cfg_s CFG,
  output cssc_pkg::cssc_gates_s GATES,
  output logic FETCH_EN,
  output logic ASYNC_IRQ_DETECT_EN,
  output logic TWI_ASYNC_ADDR_EN,
  output logic BUSY
);
  import cssc_pkg::*;

  initial begin
    if (WD_SHORT_CYCLES < 1 || WD_LONG_CYCLES < WD_SHORT_CYCLES || WD_LONG_CYCLES > 65536) begin
      $error("cssc_top: watchdog delay counts out of range");
    end
  end

  typedef enum logic [1:0] {
    CSSC_ST_SRC = 2'b00,
    CSSC_ST_WD = 2'b01,
    CSSC_ST_RUN = 2'b10
  } cssc_state_e;

  // ==========================================================================
  // Fuse decode
  // ==========================================================================
  function automatic cssc_cfg_s decode(input logic [3:0] sel, input logic [1:0] startup_time_fuses, input logic opt);
    cssc_cfg_s c;
    c = '0;
    c.freq_range = 2'h0;
    // Comparisons treat a zero bit as programmed; no inversion is needed [RL2]
    if (sel >= CSSC_SEL_XTAL_LO) begin // [RL1]
      c.src = CSSC_SRC_XTAL;
      // Range 1..3 for 101/110/111; 0 marks the wide range of the option fuse [RL12]
      c.freq_range = opt ? 2'(sel[3:1] - 3'h4) : 2'h0;
      if (!sel[0]) begin // [RL13]
        case (startup_time_fuses)
          2'h0: begin c.wake_count = CSSC_CK_258; c.reset_delay = CSSC_DLY_SHORT; end
          2'h1: begin c.wake_count = CSSC_CK_258; c.reset_delay = CSSC_DLY_LONG; end
          2'h2: begin c.wake_count = CSSC_CK_1K; c.reset_delay = CSSC_DLY_NONE; end
          default: begin c.wake_count = CSSC_CK_1K; c.reset_delay = CSSC_DLY_SHORT; end
        endcase
      end else begin
        case (startup_time_fuses)
          2'h0: begin c.wake_count = CSSC_CK_1K; c.reset_delay = CSSC_DLY_LONG; end
          2'h1: begin c.wake_count = CSSC_CK_16K; c.reset_delay = CSSC_DLY_NONE; end
          2'h2: begin c.wake_count = CSSC_CK_16K; c.reset_delay = CSSC_DLY_SHORT; end
          default: begin c.wake_count = CSSC_CK_16K; c.reset_delay = CSSC_DLY_LONG; end
        endcase
      end
    end else if (sel == CSSC_SEL_LFXTAL) begin
      c.src = CSSC_SRC_LFXTAL;
      // Reserved setting 11 falls back to the slowest, safest choice
      case (startup_time_fuses) // [RL14]
        2'h0: begin c.wake_count = CSSC_CK_1K; c.reset_delay = CSSC_DLY_SHORT; end
        2'h1: begin c.wake_count = CSSC_CK_1K; c.reset_delay = CSSC_DLY_LONG; end
        default: begin c.wake_count = CSSC_CK_32K; c.reset_delay = CSSC_DLY_LONG; end
      endcase
    end else begin
      c.src = (sel >= CSSC_SEL_RC_LO) ? CSSC_SRC_RC : CSSC_SRC_CLK;
      c.internal_rc = (sel >= CSSC_SEL_INTRC_LO) && (sel < CSSC_SEL_RC_LO);
      if (sel >= CSSC_SEL_RC_LO && startup_time_fuses == 2'h3) begin
        c.wake_count = CSSC_CK_6;
      end else begin
        c.wake_count = (sel >= CSSC_SEL_RC_LO) ? CSSC_CK_18 : CSSC_CK_6;
      end
      case (startup_time_fuses)
        2'h0: c.reset_delay = CSSC_DLY_NONE;
        2'h1: c.reset_delay = CSSC_DLY_SHORT;
        2'h2: c.reset_delay = CSSC_DLY_LONG;
        default: c.reset_delay = CSSC_DLY_SHORT;
      endcase
    end
    return c;
  endfunction : decode

  // ==========================================================================
  // Configuration capture
  // ==========================================================================
  logic [3:0] sel_eff;
  logic [1:0] sut_eff;
  cssc_cfg_s cfg_reg;
  cssc_cfg_s cfg_next;
  cssc_state_e state_reg;
  cssc_state_e state_next;

  // Unprogrammed silicon behaves as shipped [RL5]
  assign sel_eff = USE_FACTORY_FUSES ? CSSC_SEL_FACTORY : CLOCK_SOURCE_SELECT_FUSES;
  assign sut_eff = USE_FACTORY_FUSES ? CSSC_SUT_FACTORY : STARTUP_TIME_FUSES;
  assign cfg_next = decode(sel_eff, sut_eff, OSCILLATOR_OPTION_FUSE);

  // Fuses are sampled only while held in start-up, so a running clock never switches source
  // Reset loads decoded fuses as well: a cleared wake count would end the count at the first tick
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || state_reg != CSSC_ST_RUN) begin
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================================
  // Start-up sequencer
  // ==========================================================================
  logic [15:0] src_cnt_reg;
  logic [16:0] wd_cnt_reg;
  logic from_reset_reg;
  logic [16:0] wd_target;

  always_comb begin
    case (cfg_reg.reset_delay)
      CSSC_DLY_SHORT: wd_target = 17'(WD_SHORT_CYCLES);
      CSSC_DLY_LONG: wd_target = 17'(WD_LONG_CYCLES);
      default: wd_target = 17'h00000;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSSC_ST_SRC: begin
        // Source count first, then the watchdog part only when starting from reset [RL15]
        if (SRC_CLK_TICK && src_cnt_reg + 16'h0001 >= cfg_reg.wake_count) begin // [RL3]
          state_next = (from_reset_reg && wd_target != 17'h00000) ? CSSC_ST_WD : CSSC_ST_RUN;
        end
      end
      CSSC_ST_WD: begin
        if (WD_OSC_TICK && wd_cnt_reg + 17'h00001 >= wd_target) begin // [RL4]
          state_next = CSSC_ST_RUN;
        end
      end
      CSSC_ST_RUN: begin
        if (WAKE_REQ) begin
          state_next = CSSC_ST_SRC;
        end
      end
      default: state_next = CSSC_ST_SRC;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_reg <= CSSC_ST_SRC;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      from_reset_reg <= 1'b1;
    end else if (state_reg == CSSC_ST_RUN) begin
      from_reset_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || state_reg != CSSC_ST_SRC) begin
      src_cnt_reg <= 16'h0000;
    end else if (SRC_CLK_TICK) begin
      src_cnt_reg <= src_cnt_reg + 16'h0001; // [RL3]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || state_reg != CSSC_ST_WD) begin
      wd_cnt_reg <= 17'h00000;
    end else if (WD_OSC_TICK) begin
      wd_cnt_reg <= wd_cnt_reg + 17'h00001; // [RL4]
    end
  end

  // ==========================================================================
  // Clock domain gates
  // ==========================================================================
  logic running;
  logic async_ok;
  cssc_gates_s gates_reg;

  assign running = (state_reg == CSSC_ST_RUN);
  // Timer crystal shares the oscillator pins, so only an internal main clock frees them [RL10]
  assign async_ok = cfg_reg.internal_rc;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      gates_reg <= '0;
      FETCH_EN <= 1'b0;
      ASYNC_IRQ_DETECT_EN <= 1'b0;
      TWI_ASYNC_ADDR_EN <= 1'b0;
    end else begin
      gates_reg.core_en <= running && !SLEEP_CORE; // [RL6]
      gates_reg.nvm_en <= running && !SLEEP_CORE; // [RL9]
      gates_reg.peripheral_en <= running && !SLEEP_PERIPHERAL; // [RL7]
      // Converter runs whenever started, independent of core and peripheral sleep [RL11]
      gates_reg.converter_en <= running;
      gates_reg.async_timer_en <= ASYNC_TIMER_REQ && async_ok; // [RL10]
      FETCH_EN <= running && !SLEEP_CORE; // [RL6]
      ASYNC_IRQ_DETECT_EN <= !(running && !SLEEP_PERIPHERAL); // [RL7]
      TWI_ASYNC_ADDR_EN <= !(running && !SLEEP_PERIPHERAL); // [RL8]
    end
  end

  assign GATES = gates_reg;
  assign CFG = cfg_reg;
  assign BUSY = !running;

endmodule : cssc_top

// *** testbench/cssc_osc_model.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Oscillator side: selected-source and watchdog oscillator ticks
// ==========================================================================
module cssc_osc_model (
  input wire logic clk,
  input wire logic slow,
  output logic src_tick = 1'b0,
  output logic wd_tick = 1'b0
);
  logic ph = 1'b0;
  // Slow mode halves the source rate so counts are seen in source cycles
  always @(posedge clk) begin
    ph <= #1 ~ph;
    src_tick <= #1 ~slow | ph;
    wd_tick <= #1 1'b1;
  end
endmodule : cssc_osc_model

// *** testbench/cssc_top_monitor.sv ***
`timescale 1ns/100ps
// ==========================================================================
// Gating and start-up checks
// ==========================================================================
module cssc_monitor import cssc_pkg::*; #(
  parameter int WD_SHORT_CYCLES = cssc_pkg::CSSC_WD_SHORT,
  parameter int WD_LONG_CYCLES = cssc_pkg::CSSC_WD_LONG
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SRC_CLK_TICK,
  input wire logic WD_OSC_TICK,
  input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic OSCILLATOR_OPTION_FUSE,
  input wire logic USE_FACTORY_FUSES,
  input wire logic WAKE_REQ,
  input wire logic SLEEP_CORE,
  input wire logic SLEEP_PERIPHERAL,
  input wire logic ASYNC_TIMER_REQ,
  input wire cssc_pkg::cssc_cfg_s CFG,
  input wire cssc_pkg::cssc_gates_s GATES,
  input wire logic FETCH_EN,
  input wire logic ASYNC_IRQ_DETECT_EN,
  input wire logic TWI_ASYNC_ADDR_EN,
  input wire logic BUSY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_fetch_core; FETCH_EN |-> GATES.core_en; endproperty
  a_fetch_core: assert property (p_fetch_core) else $error("fetch without core clock");
  property p_nvm; GATES.nvm_en == GATES.core_en; endproperty
  a_nvm: assert property (p_nvm) else $error("nvm gate differs from core gate");
  property p_irq; GATES.peripheral_en |-> !ASYNC_IRQ_DETECT_EN; endproperty
  a_irq: assert property (p_irq) else $error("async irq detect with peripheral clock on");
  property p_twi; $rose(SLEEP_PERIPHERAL) && FETCH_EN |=> TWI_ASYNC_ADDR_EN && !GATES.peripheral_en; endproperty
  a_twi: assert property (p_twi) else $error("two-wire async address not enabled");
  property p_conv;
    SLEEP_CORE && SLEEP_PERIPHERAL && !WAKE_REQ && GATES.converter_en |=> GATES.converter_en;
  endproperty
  a_conv: assert property (p_conv) else $error("converter clock stopped in sleep");
  property p_async; GATES.async_timer_en |-> CFG.internal_rc; endproperty
  a_async: assert property (p_async) else $error("async timer off internal oscillator");
  property p_wake; FETCH_EN && WAKE_REQ |=> BUSY; endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart count");
  property p_sleep; SLEEP_CORE |=> !FETCH_EN && !GATES.nvm_en; endproperty
  a_sleep: assert property (p_sleep) else $error("fetch during core sleep");
  property p_factory;
    BUSY && USE_FACTORY_FUSES |=> CFG.internal_rc && CFG.wake_count == 16'h0006 && CFG.reset_delay == CSSC_DLY_LONG;
  endproperty
  a_factory: assert property (p_factory) else $error("factory settings not applied");
  property p_fetch_order; $rose(FETCH_EN) |-> !$past(BUSY); endproperty
  a_fetch_order: assert property (p_fetch_order) else $error("fetch before start-up ended");
  c_wake: cover property (FETCH_EN && WAKE_REQ);
  c_async: cover property (GATES.async_timer_en);
  c_sleep: cover property (ASYNC_IRQ_DETECT_EN && !GATES.core_en);
endmodule : cssc_monitor
bind cssc_top cssc_monitor #(.WD_SHORT_CYCLES(WD_SHORT_CYCLES), .WD_LONG_CYCLES(WD_LONG_CYCLES)) u_mon (
  .REF_CLK(REF_CLK),
  .RESET_N(RESET_N),
  .SRC_CLK_TICK(SRC_CLK_TICK),
  .WD_OSC_TICK(WD_OSC_TICK),
  .CLOCK_SOURCE_SELECT_FUSES(CLOCK_SOURCE_SELECT_FUSES),
  .STARTUP_TIME_FUSES(STARTUP_TIME_FUSES),
  .OSCILLATOR_OPTION_FUSE(OSCILLATOR_OPTION_FUSE),
  .USE_FACTORY_FUSES(USE_FACTORY_FUSES),
  .WAKE_REQ(WAKE_REQ),
  .SLEEP_CORE(SLEEP_CORE),
  .SLEEP_PERIPHERAL(SLEEP_PERIPHERAL),
  .ASYNC_TIMER_REQ(ASYNC_TIMER_REQ),
  .CFG(CFG),
  .GATES(GATES),
  .FETCH_EN(FETCH_EN),
  .ASYNC_IRQ_DETECT_EN(ASYNC_IRQ_DETECT_EN),
  .TWI_ASYNC_ADDR_EN(TWI_ASYNC_ADDR_EN),
  .BUSY(BUSY)
);

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
  import cssc_pkg::*;
  logic clk = 0, rst_n = 0, fac = 1, wake = 0, slp_c = 0, slp_p = 0, atr = 1, opt = 1, slow = 0;
  logic [3:0] sel = 4'hF;
  logic [1:0] startup_time_fuses = 2'h0;
  logic src_tick, wd_tick, fetch, irq_en, twi_en, busy;
  cssc_cfg_s cfg;
  cssc_gates_s gates;
  int num_errors = 0, compares = 0, cnt;
  always #50 clk = ~clk;
  cssc_osc_model u_osc (.clk(clk), .slow(slow), .src_tick(src_tick), .wd_tick(wd_tick));
  // Short watchdog counts keep the run brief
  cssc_top #(.WD_SHORT_CYCLES(8), .WD_LONG_CYCLES(16)) u_dut (.REF_CLK(clk), .RESET_N(rst_n),
    .SRC_CLK_TICK(src_tick), .WD_OSC_TICK(wd_tick), .CLOCK_SOURCE_SELECT_FUSES(sel), .STARTUP_TIME_FUSES(startup_time_fuses),
    .OSCILLATOR_OPTION_FUSE(opt), .USE_FACTORY_FUSES(fac), .WAKE_REQ(wake), .SLEEP_CORE(slp_c),
    .SLEEP_PERIPHERAL(slp_p), .ASYNC_TIMER_REQ(atr), .CFG(cfg), .GATES(gates), .FETCH_EN(fetch),
    .ASYNC_IRQ_DETECT_EN(irq_en), .TWI_ASYNC_ADDR_EN(twi_en), .BUSY(busy));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic wait_fetch();
    cnt = 0;
    while (fetch !== 1'b1 && cnt < 40000) begin
      @(posedge clk);
      #1 cnt++;
    end
  endtask : wait_fetch
  task automatic run_case(input logic [3:0] s, input logic [1:0] u, input logic o, input logic [1:0] src,
    input logic [1:0] rng, input logic [15:0] wk, input logic [1:0] dly);
    int e;
    sel = s;
    startup_time_fuses = u;
    opt = o;
    rst_n = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    wait_fetch();
    e = wk + (dly == 2'h1 ? 8 : dly == 2'h2 ? 16 : 0) + 1;
    check("source", src, cfg.src);
    check("range", rng, cfg.freq_range);
    check("wake count", wk, cfg.wake_count);
    check("reset delay", dly, cfg.reset_delay);
    check("startup in range", 1, cnt >= e && cnt <= e + 1);
    check("busy after start", 0, busy);
  endtask : run_case
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    run_case(4'hF, 2'h0, 1'b1, CSSC_SRC_CLK, 2'h0, 16'h0006, 2'h2);
    check("gates after boot", 5'h1F, gates);
    slp_c = 1;
    slp_p = 1;
    repeat (2) @(posedge clk);
    #1 check("gates asleep", 5'h03, gates);
    check("async enables", 2'h3, {irq_en, twi_en});
    check("fetch asleep", 0, fetch);
    slp_c = 0;
    slp_p = 0;
    slow = 1;
    repeat (2) @(posedge clk);
    #1 wake = 1;
    @(posedge clk);
    #1 wake = 0;
    @(posedge clk);
    #1 check("fetch held on wake", 0, fetch);
    wait_fetch();
    check("wake span", 1, cnt >= 10 && cnt <= 13);
    slow = 0;
    fac = 0;
    run_case(4'hF, 2'h3, 1'b1, CSSC_SRC_XTAL, 2'h3, 16'h4000, 2'h2);
    check("async off crystal", 0, gates.async_timer_en);
    run_case(4'hA, 2'h0, 1'b1, CSSC_SRC_XTAL, 2'h1, 16'h0102, 2'h1);
    run_case(4'hD, 2'h0, 1'b1, CSSC_SRC_XTAL, 2'h2, 16'h0400, 2'h2);
    run_case(4'hC, 2'h2, 1'b0, CSSC_SRC_XTAL, 2'h0, 16'h0400, 2'h0);
    run_case(4'h9, 2'h2, 1'b1, CSSC_SRC_LFXTAL, 2'h0, 16'h8000, 2'h2);
    run_case(4'h9, 2'h0, 1'b1, CSSC_SRC_LFXTAL, 2'h0, 16'h0400, 2'h1);
    run_case(4'h8, 2'h0, 1'b1, CSSC_SRC_RC, 2'h0, 16'h0012, 2'h0);
    run_case(4'h5, 2'h3, 1'b1, CSSC_SRC_RC, 2'h0, 16'h0006, 2'h1);
    run_case(4'h4, 2'h0, 1'b1, CSSC_SRC_CLK, 2'h0, 16'h0006, 2'h0);
    check("async on internal", 1, gates.async_timer_en);
    run_case(4'h0, 2'h1, 1'b1, CSSC_SRC_CLK, 2'h0, 16'h0006, 2'h1);
    give_verdict();
  end
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb
